// File: core/pscp_pkg.sv
package pscp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int PULSE_MAX_HZ = 67_600;
  localparam int PULSE_GAP_CYCLES = CLK_HZ / PULSE_MAX_HZ;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int AXI_ADDR_W = 8;
  localparam int CNT_W = 24;
  localparam int SPD_W = 16;
  localparam int DLY_W = 7;
  localparam int STOPS_W = 16;
  localparam int ACC_W = 33;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [AXI_ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFF_PRESET = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFF_MAXSPD = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] OFF_SYSDLY = 8'h0c;
  localparam logic [AXI_ADDR_W-1:0] OFF_COMPWIN = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] OFF_STATUS = 8'h14;
  localparam logic [AXI_ADDR_W-1:0] OFF_COUNT = 8'h18;
  localparam logic [AXI_ADDR_W-1:0] OFF_RAMPCNT = 8'h1c;
  localparam logic [AXI_ADDR_W-1:0] OFF_CARRY = 8'h20;
  localparam logic [AXI_ADDR_W-1:0] OFF_SPEED = 8'h24;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int STAT_OVR_BIT = 8;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [CNT_W-1:0] PRESET_RST = 24'h0186a0;
  localparam logic [CNT_W-1:0] PRESET_MAX = 24'h98967f;
  localparam logic [DLY_W-1:0] SYSDLY_RST = 7'h0a;
  localparam logic [DLY_W-1:0] SYSDLY_MAX = 7'h64;
  localparam logic [SPD_W-1:0] MAXSPD_RST = 16'h1388;
  localparam logic [SPD_W-1:0] COMPWIN_RST = 16'h0064;

  ////////////////////////////////////////////////////////////////////////////
  // stop modes
  localparam logic [2:0] MODE_RAMP = 3'h0;
  localparam logic [2:0] MODE_CNT_RST = 3'h1;
  localparam logic [2:0] MODE_CNT_KEEP = 3'h2;
  localparam logic [2:0] MODE_SPD = 3'h3;
  localparam logic [2:0] MODE_SPD_CNT_RST = 3'h4;
  localparam logic [2:0] MODE_SPD_CNT_KEEP = 3'h5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN = 4'h2,
    ST_DELAY = 4'h4,
    ST_RAMP = 4'h8
  } pscp_state_t;

endpackage

// File: core/pscp_sync.sv
`timescale 1ns/1ps
module pscp_sync #(
  parameter int WIDTH = 2
) (
  input logic aclk,
  input logic aresetn,
  input logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stage_r;
  logic [WIDTH-1:0] last_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // edges come from the second and third stage only
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_r[i] <= 1'b0;
          stage_r[i] <= 1'b0;
          last_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= async_in[i];
          stage_r[i] <= meta_r[i];
          last_r[i] <= stage_r[i];
        end
      end
      assign rise[i] = stage_r[i] & ~last_r[i];
      assign fall[i] = ~stage_r[i] & last_r[i];
    end
  endgenerate

endmodule

// File: core/pscp_top.sv
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// Function
// - counting stop: run until preset pulses arrive
// - counting starts on stop-to-start edge
// - speed-compensated: delay stop below max speed
// - mode 1: clear ramp-down pulses after stop
// - mode 2: deduct ramp-down pulses from preset
// - mode 0: plain ramp stop, no counting
// - pulse preset configurable, default 100000
// - pulse input handles up to 67.6 kHz
// - system delay 0-100 ms, default 10 ms
// - system delay only in speed-compensated modes
// - modes 3,4,5 are speed-compensated variants
module pscp_top
  import pscp_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input logic aclk,
  input logic aresetn,
  input logic [AXI_ADDR_W-1:0] awaddr,
  input logic [2:0] awprot,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [AXI_ADDR_W-1:0] araddr,
  input logic [2:0] arprot,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  input logic pulse_in,
  input logic start_in,
  input logic [SPD_W-1:0] speed_in,
  input logic zero_speed_in,
  output logic stop_req,
  output logic running
);

  localparam int MS_W = $clog2(MS_CYC + 1);
  localparam int GAP_W = $clog2(PULSE_GAP_CYCLES + 1);

  pscp_state_t state_r;
  logic [2:0] mode_r;
  logic [2:0] run_mode_r;
  logic [CNT_W-1:0] preset_r;
  logic [SPD_W-1:0] maxspd_r;
  logic [DLY_W-1:0] sysdly_r;
  logic [SPD_W-1:0] compwin_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] ramp_cnt_r;
  logic [CNT_W-1:0] carry_r;
  logic [STOPS_W-1:0] stops_r;
  logic [ACC_W-1:0] dly_acc_r;
  logic [ACC_W-1:0] dly_goal_r;
  logic [SPD_W-1:0] dly_step_r;
  logic [MS_W-1:0] ms_cnt_r;
  logic [GAP_W-1:0] gap_r;
  logic ovr_r;
  logic aw_full_r;
  logic w_full_r;
  logic [AXI_ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] rise;
  logic [1:0] fall;
  logic pulse_rise;
  logic start_rise;
  logic start_fall;
  logic cnt_mode;
  logic spd_mode;
  logic keep_mode;
  logic [CNT_W-1:0] target;
  logic count_hit;
  logic stop_event;
  logic enter_ramp;
  logic ramp_exit;
  logic delay_done;
  logic ms_tick;
  logic [SPD_W-1:0] spd_gap;
  logic wr_fire;
  logic wr_hit;
  logic [AXI_ADDR_W-1:0] wr_off;
  logic [AXI_ADDR_W-1:0] rd_off;
  logic [31:0] rd_word;
  logic rd_hit;
  logic ovr_clr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit 0 pulse, bit 1 start

  pscp_sync #(
    .WIDTH(2)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({start_in, pulse_in}),
    .rise(rise),
    .fall(fall)
  );

  assign pulse_rise = rise[0];
  assign start_rise = rise[1];
  assign start_fall = fall[1];

  //////////////////////////////////////////////////////////////////////////////
  // mode decode, latched at start so a mid-run write cannot tear a cycle

  assign spd_mode = (run_mode_r == MODE_SPD) || (run_mode_r == MODE_SPD_CNT_RST) ||
                    (run_mode_r == MODE_SPD_CNT_KEEP);
  // mode 0 and 3 never count
  assign cnt_mode = (run_mode_r == MODE_CNT_RST) || (run_mode_r == MODE_CNT_KEEP) ||
                    (run_mode_r == MODE_SPD_CNT_RST) || (run_mode_r == MODE_SPD_CNT_KEEP);
  assign keep_mode = (run_mode_r == MODE_CNT_KEEP) || (run_mode_r == MODE_SPD_CNT_KEEP);

  assign target = (keep_mode && (carry_r >= preset_r)) ? '0 : (keep_mode ? preset_r - carry_r : preset_r);

  assign count_hit = cnt_mode && (count_r >= target);
  assign stop_event = (state_r == ST_RUN) && (start_fall || count_hit);
  assign enter_ramp = (stop_event && !spd_mode) || ((state_r == ST_DELAY) && delay_done);
  assign ramp_exit = (state_r == ST_RAMP) && zero_speed_in;

  //////////////////////////////////////////////////////////////////////////////
  // state machine

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          // run opens on the start edge
          if (start_rise) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (stop_event) begin
            state_r <= spd_mode ? ST_DELAY : ST_RAMP;
          end
        end
        ST_DELAY: begin
          if (delay_done) begin
            state_r <= ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (zero_speed_in) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_mode_r <= MODE_RST;
    end else if ((state_r == ST_IDLE) && start_rise) begin
      run_mode_r <= mode_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // speed-compensated delay: wait until the distance lost to the speed shortfall
  // over the window is matched at full-speed rate, minus the sensor latency

  assign spd_gap = (speed_in >= maxspd_r) ? '0 : maxspd_r - speed_in;
  assign ms_tick = (ms_cnt_r == MS_W'(MS_CYC - 1));
  assign delay_done = (dly_acc_r >= dly_goal_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_r <= '0;
    end else if ((state_r != ST_DELAY) || ms_tick) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly_acc_r <= '0;
      dly_goal_r <= '0;
      dly_step_r <= '0;
    end else if (stop_event && spd_mode) begin
      // latency counts as delay already spent
      dly_acc_r <= {{(ACC_W-DLY_W){1'b0}}, sysdly_r} * {{(ACC_W-SPD_W){1'b0}}, maxspd_r};
      dly_goal_r <= {{(ACC_W-SPD_W){1'b0}}, compwin_r} * {{(ACC_W-SPD_W){1'b0}}, spd_gap};
      dly_step_r <= maxspd_r;
    end else if ((state_r == ST_DELAY) && ms_tick && !delay_done) begin
      dly_acc_r <= dly_acc_r + {{(ACC_W-SPD_W){1'b0}}, dly_step_r};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pulse counters

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
    end else if ((state_r == ST_IDLE) && start_rise) begin
      count_r <= '0;
    end else if (cnt_mode && pulse_rise && (state_r == ST_RUN || state_r == ST_DELAY) && (&count_r == 1'b0)) begin
      count_r <= count_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp_cnt_r <= '0;
    end else if (enter_ramp) begin
      ramp_cnt_r <= '0;
    end else if (ramp_exit && !keep_mode) begin
      ramp_cnt_r <= '0;
    end else if (cnt_mode && pulse_rise && (state_r == ST_RAMP) && (&ramp_cnt_r == 1'b0)) begin
      ramp_cnt_r <= ramp_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_r <= '0;
    end else if (wr_fire && (wr_off == OFF_PRESET)) begin
      carry_r <= '0;
    end else if (ramp_exit && cnt_mode) begin
      if (keep_mode) begin
        carry_r <= (carry_r + ramp_cnt_r < carry_r) ? '1 : carry_r + ramp_cnt_r;
      end else begin
        carry_r <= '0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stops_r <= '0;
    end else if (ramp_exit) begin
      stops_r <= stops_r + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pulse rate watch: edges closer than the top rate may have been merged

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r <= GAP_W'(PULSE_GAP_CYCLES);
    end else if (pulse_rise) begin
      gap_r <= '0;
    end else if (gap_r != GAP_W'(PULSE_GAP_CYCLES)) begin
      gap_r <= gap_r + 1'b1;
    end
  end

  assign ovr_clr = wr_fire && (wr_off == OFF_STATUS) && w_strb_r[1] && w_data_r[STAT_OVR_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_r <= 1'b0;
    end else if (pulse_rise && (gap_r < GAP_W'(PULSE_GAP_CYCLES - 1))) begin
      ovr_r <= 1'b1;
    end else if (ovr_clr) begin
      ovr_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // drive-side outputs

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_req <= 1'b0;
      running <= 1'b0;
    end else begin
      if (enter_ramp) begin
        stop_req <= 1'b1;
      end else if (ramp_exit) begin
        stop_req <= 1'b0;
      end
      if ((state_r == ST_IDLE) && start_rise) begin
        running <= 1'b1;
      end else if (ramp_exit) begin
        running <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers

  assign wr_off = {aw_addr_r[AXI_ADDR_W-1:2], 2'b00};
  assign wr_fire = aw_full_r && w_full_r && !bvalid;
  assign wr_hit = (wr_off <= OFF_SPEED);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= MODE_RST;
      preset_r <= PRESET_RST;
      maxspd_r <= MAXSPD_RST;
      sysdly_r <= SYSDLY_RST;
      compwin_r <= COMPWIN_RST;
    end else if (wr_fire) begin
      case (wr_off)
        OFF_CTRL: begin
          // unknown codes keep the old mode
          if (merge({29'h0, mode_r}, w_data_r, w_strb_r) <= {29'h0, MODE_SPD_CNT_KEEP}) begin
            mode_r <= w_strb_r[0] ? w_data_r[2:0] : mode_r;
          end
        end
        OFF_PRESET: begin
          if (merge({8'h0, preset_r}, w_data_r, w_strb_r) > {8'h0, PRESET_MAX}) begin
            preset_r <= PRESET_MAX;
          end else begin
            preset_r <= CNT_W'(merge({8'h0, preset_r}, w_data_r, w_strb_r));
          end
        end
        OFF_MAXSPD: maxspd_r <= SPD_W'(merge({16'h0, maxspd_r}, w_data_r, w_strb_r));
        OFF_SYSDLY: begin
          if (merge({25'h0, sysdly_r}, w_data_r, w_strb_r) > {25'h0, SYSDLY_MAX}) begin
            sysdly_r <= SYSDLY_MAX;
          end else begin
            sysdly_r <= w_strb_r[0] ? w_data_r[DLY_W-1:0] : sysdly_r;
          end
        end
        OFF_COMPWIN: compwin_r <= SPD_W'(merge({16'h0, compwin_r}, w_data_r, w_strb_r));
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channels

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_full_r <= 1'b1;
      aw_addr_r <= awaddr;
    end else if (wr_fire) begin
      aw_full_r <= 1'b0;
    end else if (!aw_full_r && !bvalid) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_full_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_full_r <= 1'b1;
      w_data_r <= wdata;
      w_strb_r <= wstrb;
    end else if (wr_fire) begin
      w_full_r <= 1'b0;
    end else if (!w_full_r && !bvalid) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channels

  assign rd_off = {araddr[AXI_ADDR_W-1:2], 2'b00};

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (rd_off)
      OFF_CTRL: rd_word = {29'h0, mode_r};
      OFF_PRESET: rd_word = {8'h0, preset_r};
      OFF_MAXSPD: rd_word = {16'h0, maxspd_r};
      OFF_SYSDLY: rd_word = {25'h0, sysdly_r};
      OFF_COMPWIN: rd_word = {16'h0, compwin_r};
      OFF_STATUS: rd_word = {stops_r, 7'h0, ovr_r, 2'h0, running, stop_req, state_r};
      OFF_COUNT: rd_word = {8'h0, count_r};
      OFF_RAMPCNT: rd_word = {8'h0, ramp_cnt_r};
      OFF_CARRY: rd_word = {8'h0, carry_r};
      OFF_SPEED: rd_word = {16'h0, speed_in};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid && !arready) begin
      arready <= 1'b1;
    end
  end

endmodule

// File: test/pscp_asserts.sv
`timescale 1ns/1ps
module pscp_asserts
  import pscp_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input logic aclk,
  input logic aresetn,
  input logic awvalid,
  input logic awready,
  input logic wvalid,
  input logic wready,
  input logic [1:0] bresp,
  input logic bvalid,
  input logic bready,
  input logic arvalid,
  input logic arready,
  input logic [31:0] rdata,
  input logic rvalid,
  input logic rready,
  input logic start_in,
  input logic zero_speed_in,
  input logic stop_req,
  input logic running
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  // read slot reopens only after the data beat is gone
  sequence s_rd_back;
    !rvalid ##1 arready;
  endsequence
  wr_resp_a: assert property (s_wr_take |=> !awready && !wready ##1 bvalid)
    else $error("write response not two cycles after handshake");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rd_lat_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data not one cycle after address");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before taken");
  rd_back_a: assert property (rvalid && rready |=> s_rd_back)
    else $error("read slot not reopened");
  stop_run_a: assert property (stop_req |-> running)
    else $error("stop raised while not running");
  stop_hold_a: assert property (stop_req && !zero_speed_in |=> stop_req)
    else $error("stop dropped before zero speed");
  stop_end_a: assert property (stop_req && zero_speed_in |=> !stop_req && !running)
    else $error("cycle not ended at zero speed");
  zs_ignore_a: assert property (running && !stop_req && zero_speed_in |=> running)
    else $error("zero speed ended a cycle outside ramp");
  run_edge_a: assert property ($rose(running) |-> $past(start_in, 3) && !stop_req)
    else $error("running rose without a start edge");
endmodule

bind pscp_top pscp_asserts #(.MS_CYC(MS_CYC)) chk_u (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .start_in,
  .zero_speed_in, .stop_req, .running);

// File: test/pscp_partner.sv
`timescale 1ns/1ps
module pscp_partner
  import pscp_pkg::*;
(
  input logic aclk,
  output logic pulse_pin,
  output logic start_pin
);
  initial begin
    pulse_pin = 1'b0;
    start_pin = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // plain start and stop, and pulse trains
  task automatic cmd(input logic lvl);
    @(posedge aclk);
    start_pin <= lvl;
  endtask
  task automatic pulses(input int n, input int gap);
    repeat (n) begin
      @(posedge aclk);
      pulse_pin <= 1'b1;
      repeat (8) @(posedge aclk);
      pulse_pin <= 1'b0;
      repeat (gap - 8) @(posedge aclk);
    end
  endtask
endmodule

// File: test/pscp_tb_top.sv
`timescale 1ns/1ps
module pscp_tb_top
  import pscp_pkg::*;
;
  localparam int GAP = PULSE_GAP_CYCLES + 5;
  localparam int LIMIT = 40000;
  logic aclk;
  logic aresetn;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs, bs;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, zero_spd;
  logic awready, wready, bvalid, arready, rvalid, stop_req, running, pulse_pin, start_pin;
  logic [SPD_W-1:0] speed;
  int bad_count, n_tests, cyc, n;
  logic [2:0] t_mode [6] = '{MODE_RAMP, MODE_SPD, MODE_SPD, MODE_SPD, MODE_SPD_CNT_RST, MODE_SPD_CNT_KEEP};
  int t_dly [6] = '{10, 0, 10, 0, 10, 10};
  logic [SPD_W-1:0] t_spd [6] = '{16'h0fa0, 16'h0fa0, 16'h0fa0, 16'h1388, 16'h0fa0, 16'h0fa0};
  int t_lo [6] = '{0, 390, 190, 0, 190, 190};
  int t_hi [6] = '{12, 440, 240, 12, 240, 240};

  pscp_top #(.MS_CYC(20)) dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pulse_in(pulse_pin), .start_in(start_pin), .speed_in(speed), .zero_speed_in(zero_spd),
    .stop_req(stop_req), .running(running));
  pscp_partner partner_u (.aclk(aclk), .pulse_pin(pulse_pin), .start_pin(start_pin));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic ticks(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        ad = 1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wd = 1;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // bounded wait on running (sel 1) or stop_req (sel 0), k counts edges
  task automatic wait_sig(input bit sel, input logic lvl, output int k);
    k = 0;
    while (((sel ? running : stop_req) !== lvl) && k < 3000) begin
      @(posedge aclk);
      k++;
    end
  endtask
  task automatic cyc_start();
    partner_u.cmd(1'b1);
    wait_sig(1, 1'b1, n);
    @(posedge aclk);
    zero_spd <= 1'b1;
    ticks(2);
    zero_spd <= 1'b0;
    chk(running, 1'b1);
  endtask
  task automatic cyc_end();
    @(posedge aclk);
    zero_spd <= 1'b1;
    wait_sig(1, 1'b0, n);
    zero_spd <= 1'b0;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, speed} = '0;
    {awprot, arprot} = '0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready, zero_spd} = '0;
    ticks(12);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(OFF_PRESET);
    chk(rd, 32'h000186a0);
    axi_rd(OFF_SYSDLY);
    chk(rd, 32'h0000000a);
    axi_rd(8'h28);
    chk(rs, RESP_SLVERR);
    axi_wr(8'h28, 32'h00000001);
    chk(bs, RESP_SLVERR);
    axi_wr(OFF_SYSDLY, 32'h000000ff);
    chk(bs, RESP_OKAY);
    axi_rd(OFF_SYSDLY);
    chk(rd, 32'h00000064);
    axi_wr(OFF_CTRL, MODE_CNT_RST);
    axi_wr(OFF_PRESET, 32'h3);
    cyc_start();
    partner_u.pulses(2, GAP);
    chk(stop_req, 1'b0);
    partner_u.pulses(1, GAP);
    chk(stop_req, 1'b1);
    axi_rd(OFF_COUNT);
    chk(rd, 32'h3);
    partner_u.pulses(1, GAP);
    axi_rd(OFF_RAMPCNT);
    chk(rd, 32'h1);
    cyc_end();
    axi_rd(OFF_RAMPCNT);
    chk(rd, 32'h0);
    ticks(20);
    chk(running, 1'b0);
    partner_u.cmd(1'b0);
    ticks(5);
    axi_wr(OFF_CTRL, MODE_CNT_KEEP);
    axi_wr(OFF_PRESET, 32'h3);
    cyc_start();
    partner_u.pulses(4, GAP);
    cyc_end();
    axi_rd(OFF_CARRY);
    chk(rd, 32'h1);
    partner_u.cmd(1'b0);
    ticks(5);
    cyc_start();
    partner_u.pulses(2, GAP);
    chk(stop_req, 1'b1);
    cyc_end();
    partner_u.cmd(1'b0);
    ticks(5);
    axi_wr(OFF_CTRL, MODE_RAMP);
    cyc_start();
    partner_u.pulses(2, 100);
    chk(stop_req, 1'b0);
    axi_rd(OFF_COUNT);
    chk(rd, 32'h0);
    axi_rd(OFF_STATUS);
    chk(rd[STAT_OVR_BIT], 1'b1);
    wstrb <= 4'h1;
    axi_wr(OFF_STATUS, 32'h00000100);
    axi_rd(OFF_STATUS);
    chk(rd[STAT_OVR_BIT], 1'b1);
    wstrb <= 4'hf;
    axi_wr(OFF_STATUS, 32'h00000100);
    axi_rd(OFF_STATUS);
    chk(rd[STAT_OVR_BIT], 1'b0);
    partner_u.cmd(1'b0);
    wait_sig(0, 1'b1, n);
    cyc_end();
    for (int i = 0; i < 6; i++) begin
      axi_wr(OFF_CTRL, t_mode[i]);
      axi_wr(OFF_SYSDLY, t_dly[i]);
      speed <= t_spd[i];
      cyc_start();
      ticks(5);
      partner_u.cmd(1'b0);
      wait_sig(0, 1'b1, n);
      chk(n >= t_lo[i] && n <= t_hi[i], 1'b1);
      cyc_end();
    end
    wrap_up();
  end
endmodule
